// file: design/sewp_dev.sv
// Contract
// - Data stable while clock high; else framing
// - Clock-high data fall is start, anytime
// - Clock-high data rise is stop; standby
// - Acknowledge each 8-bit word on ninth clock
// - Standby at power-up and after stop
// - Controller recovers bus with nine clocks
// - Device address follows start; five-bit pattern
// - Chip-select bits must equal strap pins
// - Floating straps read as low
// - Last address bit selects read or write
// - Ack on match, else silent standby
// - Write-protect high inhibits all writes
// - Two address bytes then data, each acked
// - Stop starts self-timed program cycle
// - Ignore bus during program cycle
// - Page write up to 64 bytes
// - Advance low six address bits, wrap
// - Poll: ack only after programming done
// - Sample on clock rise, change on fall
// - Unconnected write-protect reads as low
// - 64-byte pages, 15-bit word address
`timescale 1ns/10ps
`default_nettype none
module sewp_dev #(
  parameter int PROG_CYCLES = sewp_pkg::PROG_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Link side.
  sewp_if.dev bus,
  // Strap and protect pins.
  input wire logic chip_select_strap_hi,
  input wire logic chip_select_strap_lo,
  input wire logic write_protect,
  // Nonvolatile array write port.
  output logic mem_we,
  output logic [sewp_pkg::ADDR_W-1:0] mem_addr,
  output logic [sewp_pkg::BYTE_W-1:0] mem_data,
  // Status.
  output logic standby,
  output logic programming
);
  import sewp_pkg::*;

  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_DEV = 6'h02,
    D_AHI = 6'h04,
    D_ALO = 6'h08,
    D_DATA = 6'h10,
    D_PROG = 6'h20
  } sewp_dev_st_t;

  typedef struct packed {
    sewp_dev_st_t st;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    logic [1:0] wp_s;
    logic [1:0] hi_s;
    logic [1:0] lo_s;
    logic [3:0] bitcnt;
    logic [BYTE_W-1:0] shreg;
    logic ackph;
    logic [ADDR_W-1:0] addr;
    logic [PAGE_BYTES-1:0] vld;
    logic [PAGE_BYTES-1:0][BYTE_W-1:0] pbuf;
    logic [PIDX_W-1:0] pidx;
    logic [TMR_W-1:0] timer;
    logic drv_lvl;
    logic sda_oe_n;
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [BYTE_W-1:0] mem_data;
  } sewp_dev_t;

  localparam sewp_dev_t DEV_RST = '{
    st: D_IDLE, scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
    sda_oe_n: 1'b1, default: '0
  };
  localparam logic [TMR_W-1:0] PROG_LAST = TMR_W'(PROG_CYCLES - 1);

  sewp_dev_t r;
  sewp_dev_t r_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic addr_match;

  // Edge and framing detection on the second synchroniser stage only.
  always_comb begin
    scl_rise = r.scl_s[1] & ~r.scl_d;
    scl_fall = ~r.scl_s[1] & r.scl_d;
    start_seen = r.scl_s[1] & r.scl_d & r.sda_d & ~r.sda_s[1];
    stop_seen = r.scl_s[1] & r.scl_d & ~r.sda_d & r.sda_s[1];
    // Pad pull-downs make open straps arrive as low levels here.
    addr_match = (r.shreg[7:3] == DEV_TYPE) &&
                 (r.shreg[2:1] == {r.hi_s[1], r.lo_s[1]});
  end

  // Next-state logic of the whole target.
  always_comb begin
    r_nxt = r;
    r_nxt.scl_s = {r.scl_s[0], bus.scl};
    r_nxt.sda_s = {r.sda_s[0], bus.sda};
    r_nxt.wp_s = {r.wp_s[0], write_protect};
    r_nxt.hi_s = {r.hi_s[0], chip_select_strap_hi};
    r_nxt.lo_s = {r.lo_s[0], chip_select_strap_lo};
    r_nxt.scl_d = r.scl_s[1];
    r_nxt.sda_d = r.sda_s[1];
    r_nxt.mem_we = 1'b0;
    case (r.st)
      D_PROG: begin
        // Bus is ignored entirely until the program time has run out.
        r_nxt.sda_oe_n = 1'b1;
        if (!r.pidx[PIDX_W-1]) begin
          if (r.vld[r.pidx[OFS_W-1:0]]) begin
            r_nxt.mem_we = 1'b1;
            r_nxt.mem_addr = {r.addr[ADDR_W-1:OFS_W], r.pidx[OFS_W-1:0]};
            r_nxt.mem_data = r.pbuf[r.pidx[OFS_W-1:0]];
          end
          r_nxt.pidx = r.pidx + 1'b1;
        end
        r_nxt.timer = r.timer + 1'b1;
        if (r.timer == PROG_LAST) begin
          r_nxt.st = D_IDLE;
          r_nxt.vld = '0;
        end
      end
      default: begin
        if (start_seen) begin
          // A start is honoured in every state but D_PROG and abandons unfinished writes.
          r_nxt.st = D_DEV;
          r_nxt.bitcnt = '0;
          r_nxt.ackph = 1'b0;
          r_nxt.sda_oe_n = 1'b1;
          r_nxt.vld = '0;
        end else if (stop_seen) begin
          r_nxt.ackph = 1'b0;
          r_nxt.sda_oe_n = 1'b1;
          if (r.st == D_DATA && |r.vld && !r.wp_s[1]) begin
            r_nxt.st = D_PROG;
            r_nxt.pidx = '0;
            r_nxt.timer = '0;
          end else begin
            r_nxt.st = D_IDLE;
            r_nxt.vld = '0;
          end
        end else if (r.st != D_IDLE || r.ackph) begin
          if (scl_rise && !r.ackph) begin
            r_nxt.shreg = {r.shreg[BYTE_W-2:0], r.sda_s[1]};
            r_nxt.bitcnt = r.bitcnt + 1'b1;
          end else if (scl_fall && r.ackph) begin
            // Let go of the line once the ninth clock has ended.
            r_nxt.ackph = 1'b0;
            r_nxt.sda_oe_n = 1'b1;
            r_nxt.bitcnt = '0;
          end else if (scl_fall && r.bitcnt == 4'(ACK_BIT)) begin
            // A whole word is in; drive the acknowledge on this falling edge, except for a device address that does not match.
            r_nxt.ackph = 1'b1;
            r_nxt.sda_oe_n = 1'b0;
            case (r.st)
              D_DEV: begin
                if (!addr_match) begin
                  r_nxt.st = D_IDLE;
                  r_nxt.ackph = 1'b0;
                  r_nxt.sda_oe_n = 1'b1;
                end else if (r.shreg[0]) begin
                  r_nxt.st = D_IDLE;
                end else begin
                  r_nxt.st = D_AHI;
                end
              end
              D_AHI: begin
                r_nxt.addr[ADDR_W-1:BYTE_W] = r.shreg[ADDR_W-BYTE_W-1:0];
                r_nxt.st = D_ALO;
              end
              D_ALO: begin
                r_nxt.addr[BYTE_W-1:0] = r.shreg;
                r_nxt.st = D_DATA;
              end
              default: begin
                r_nxt.pbuf[r.addr[OFS_W-1:0]] = r.shreg;
                r_nxt.vld[r.addr[OFS_W-1:0]] = 1'b1;
                r_nxt.addr[OFS_W-1:0] = r.addr[OFS_W-1:0] + 1'b1;
              end
            endcase
          end
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= DEV_RST;
    end else begin
      r <= r_nxt;
    end
  end

  // Outputs straight from the state register.
  assign bus.dev_sda_o = r.drv_lvl;
  assign bus.dev_sda_oe_n = r.sda_oe_n;
  assign mem_we = r.mem_we;
  assign mem_addr = r.mem_addr;
  assign mem_data = r.mem_data;
  assign standby = r.st[0];
  assign programming = r.st[5];
endmodule
`default_nettype wire

// file: design/sewp_pkg.sv
`default_nettype none
package sewp_pkg;
  // ==========================================================================
  // Link framing.
  localparam int BYTE_W = 8;
  localparam int ACK_BIT = 8;
  localparam logic [4:0] DEV_TYPE = 5'h14;
  // ==========================================================================
  // Memory organisation.
  localparam int ADDR_W = 15;
  localparam int OFS_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int PIDX_W = 7;
  // ==========================================================================
  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_MS = 10;
  localparam int PROG_CYC = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TMR_W = 20;
  localparam int SCL_PERIOD_NS = 3000;
  localparam int QTR_CYC = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
  localparam int QCNT_W = 8;
  localparam logic [3:0] REC_LAST = 4'h8;
  // ==========================================================================
  // Controller registers, byte offsets on the software port.
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] REG_CMD = 8'h00;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_BYTE_BIT = 1;
  localparam int CMD_STOP_BIT = 2;
  localparam int CMD_REC_BIT = 3;
  localparam int CMD_DATA_LSB = 8;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_NACK_BIT = 1;
  localparam int STS_REC_FAIL_BIT = 2;
endpackage
`default_nettype wire

// file: design/sewp_if.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Two-wire link: controller clock and a wired-AND data line.
interface sewp_if;
  logic scl;
  logic ctl_sda_o;
  logic ctl_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;
  // The line is low when any enabled driver pulls it low, else the pull-up wins.
  assign sda = ~((~ctl_sda_oe_n & ~ctl_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport ctl (output scl, output ctl_sda_o, output ctl_sda_oe_n, input sda);
endinterface
`default_nettype wire

// file: design/sewp_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module sewp_ctl (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Software register port.
  input wire logic [sewp_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Link side.
  sewp_if.ctl bus
);
  import sewp_pkg::*;

  typedef enum logic [4:0] {
    C_IDLE = 5'h01,
    C_START = 5'h02,
    C_BIT = 5'h04,
    C_STOP = 5'h08,
    C_REC = 5'h10
  } sewp_ctl_st_t;

  typedef struct packed {
    sewp_ctl_st_t st;
    logic [1:0] q;
    logic [QCNT_W-1:0] qcnt;
    logic [3:0] bitn;
    logic [BYTE_W-1:0] tx;
    logic has_byte;
    logic stop_after;
    logic scl;
    logic drv_lvl;
    logic sda_oe_n;
    logic [1:0] sda_s;
    logic nack;
    logic [3:0] rec_cnt;
    logic rec_fail;
    logic [31:0] rdata;
  } sewp_ctl_t;

  localparam sewp_ctl_t CTL_RST = '{
    st: C_IDLE, scl: 1'b1, sda_oe_n: 1'b1, sda_s: 2'h3, default: '0
  };
  localparam logic [QCNT_W-1:0] QTR_LAST = QCNT_W'(QTR_CYC - 1);

  sewp_ctl_t r;
  sewp_ctl_t n;
  logic tick;

  // Sequencer: every bus phase is four quarter periods of the link clock, but a recovery clock that sees the line high ends after three.
  always_comb begin
    n = r;
    tick = (r.qcnt == QTR_LAST);
    n.sda_s = {r.sda_s[0], bus.sda};
    n.rdata = '0;
    n.qcnt = (r.st == C_IDLE || tick) ? '0 : r.qcnt + 1'b1;
    if (r.st != C_IDLE && tick) begin
      n.q = r.q + 1'b1;
    end
    if (r.st != C_IDLE && tick) begin
      case (r.st)
        C_START: begin
          case (r.q)
            2'h0: n.sda_oe_n = 1'b1;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda_oe_n = 1'b0;
            default: begin
              n.scl = 1'b0;
              n.bitn = '0;
              n.st = r.has_byte ? C_BIT : (r.stop_after ? C_STOP : C_IDLE);
            end
          endcase
        end
        C_BIT: begin
          case (r.q)
            2'h0: n.sda_oe_n = (r.bitn == 4'(ACK_BIT)) ? 1'b1 : r.tx[BYTE_W-1];
            2'h1: n.scl = 1'b1;
            2'h2: begin
              if (r.bitn == 4'(ACK_BIT)) begin
                n.nack = r.sda_s[1];
              end
            end
            default: begin
              n.scl = 1'b0;
              n.tx = {r.tx[BYTE_W-2:0], 1'b0};
              n.bitn = r.bitn + 1'b1;
              if (r.bitn == 4'(ACK_BIT)) begin
                n.st = r.stop_after ? C_STOP : C_IDLE;
              end
            end
          endcase
        end
        C_STOP: begin
          case (r.q)
            2'h0: n.sda_oe_n = 1'b0;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda_oe_n = 1'b1;
            default: n.st = C_IDLE;
          endcase
        end
        default: begin
          // Recovery: clock until the line is seen high during clock high.
          case (r.q)
            2'h0: begin
              n.scl = 1'b0;
              n.sda_oe_n = 1'b1;
            end
            2'h1: n.scl = 1'b1;
            2'h2: begin
              if (r.sda_s[1]) begin
                n.st = C_START;
                n.q = 2'h0;
                n.has_byte = 1'b0;
                n.stop_after = 1'b1;
              end
            end
            default: begin
              n.scl = 1'b0;
              n.rec_cnt = r.rec_cnt + 1'b1;
              if (r.rec_cnt == REC_LAST) begin
                n.rec_fail = 1'b1;
                n.st = C_IDLE;
              end
            end
          endcase
        end
      endcase
    end
    // Command register write; ignored while a sequence is running.
    if (reg_wr && reg_addr == REG_CMD && r.st == C_IDLE) begin
      n.q = '0;
      n.tx = reg_wdata[CMD_DATA_LSB +: BYTE_W];
      n.has_byte = reg_wdata[CMD_BYTE_BIT];
      n.stop_after = reg_wdata[CMD_STOP_BIT];
      n.bitn = '0;
      if (reg_wdata[CMD_REC_BIT]) begin
        n.st = C_REC;
        n.rec_cnt = '0;
        n.rec_fail = 1'b0;
      end else if (reg_wdata[CMD_START_BIT]) begin
        n.st = C_START;
      end else if (reg_wdata[CMD_BYTE_BIT]) begin
        n.st = C_BIT;
      end else if (reg_wdata[CMD_STOP_BIT]) begin
        n.st = C_STOP;
      end
    end
    // Status read; data stand only in the following cycle.
    if (reg_rd && reg_addr == REG_STATUS) begin
      n.rdata[STS_BUSY_BIT] = (r.st != C_IDLE);
      n.rdata[STS_NACK_BIT] = r.nack;
      n.rdata[STS_REC_FAIL_BIT] = r.rec_fail;
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= CTL_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register.
  assign bus.scl = r.scl;
  assign bus.ctl_sda_o = r.drv_lvl;
  assign bus.ctl_sda_oe_n = r.sda_oe_n;
  assign reg_rdata = r.rdata;
endmodule
`default_nettype wire

// file: tb/sewp_props.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Link checker beside the shared two-wire interface.
module sewp_props #(
  parameter int PROG_CYCLES = 200
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Link and device status.
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe_n,
  input wire logic programming,
  input wire logic standby
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  localparam int ACK_LIMIT = 1100;
  logic [31:0] cnt_r;
  logic [10:0] ack_cnt_r;
  // Counts the cycles for which the device has held its acknowledge low.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_cnt_r <= 11'h000;
    end else begin
      ack_cnt_r <= dev_sda_oe_n ? 11'h000 : ack_cnt_r + 11'h001;
    end
  end
  // Counts the cycles of the current program cycle.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= programming ? cnt_r + 32'h1 : 32'h0;
    end
  end
  sequence s_stop;
    scl && $rose(sda);
  endsequence
  sequence s_ack_start;
    $fell(dev_sda_oe_n);
  endsequence
  a_dev_edge_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device data moved while clock high");
  a_prog_silent: assert property (programming |-> dev_sda_oe_n)
    else $error("device drove the line while programming");
  a_ack_hold: assert property (s_ack_start |-> !dev_sda_oe_n until_with $fell(scl))
    else $error("acknowledge dropped before the ninth clock ended");
  a_ack_bound: assert property (ack_cnt_r <= ACK_LIMIT)
    else $error("acknowledge clock did not end in time");
  a_ack_release: assert property (!dev_sda_oe_n && $fell(scl) |-> ##[1:8] dev_sda_oe_n)
    else $error("data line not released after acknowledge");
  a_prog_length: assert property ($fell(programming) |->
    cnt_r >= PROG_CYCLES - 4 && cnt_r <= PROG_CYCLES + 4)
    else $error("program cycle length wrong");
  a_stop_idle: assert property (s_stop |-> ##[1:80] (standby || programming))
    else $error("stop did not lead to standby or programming");
  a_done_standby: assert property ($fell(programming) |-> ##[0:2] standby)
    else $error("no standby after program cycle");
endmodule
`default_nettype wire

// file: tb/tb_serial_eeprom_write_port.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Controller and device joined across one link.
module tb_serial_eeprom_write_port;
  import sewp_pkg::*;
  localparam int PROG = 5000;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic strap_hi = 1'b1;
  logic strap_lo = 1'b0;
  logic wp = 1'b0;
  logic mem_we, standby, programming;
  logic [14:0] mem_addr;
  logic [7:0] mem_data;
  logic [7:0] mem [int];
  int errors = 0;
  int tests_run = 0;
  int writes = 0;
  sewp_if link();
  sewp_ctl u_sewp_ctl (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus(link));
  sewp_dev #(.PROG_CYCLES(PROG)) u_sewp_dev (.ref_clk(ref_clk), .resetn(resetn), .bus(link),
    .chip_select_strap_hi(strap_hi), .chip_select_strap_lo(strap_lo), .write_protect(wp),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_data(mem_data), .standby(standby),
    .programming(programming));
  sewp_props #(.PROG_CYCLES(PROG)) chk_link (.ref_clk(ref_clk), .resetn(resetn),
    .scl(link.scl), .sda(link.sda), .dev_sda_oe_n(link.dev_sda_oe_n),
    .programming(programming), .standby(standby));
  // Clock generator.
  always #5 ref_clk = ~ref_clk;
  // Records every array write the device makes.
  always @(posedge ref_clk) begin
    if (mem_we === 1'b1) begin
      mem[int'(mem_addr)] = mem_data;
      writes++;
    end
  end
  // Compares one value and counts it.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compares one array location; a missing one reads as all ones.
  task automatic chk_mem(input int a, input logic [7:0] d);
    chk("array data", {24'h0, d}, mem.exists(a) ? {24'h0, mem[a]} : 32'hFFFFFFFF);
  endtask
  // Prints the verdict and ends the run.
  task automatic close_out();
    if (errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One register write cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // One register read; the data stand in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Issues one command and polls status, bounded, until it is done.
  task automatic cmd(input logic [31:0] c, output logic [31:0] s);
    int n = 0;
    wr(REG_CMD, c);
    do begin
      rd(REG_STATUS, s);
      n++;
    end while (s[STS_BUSY_BIT] !== 1'b0 && n < 20000);
    chk("command done", 32'h0, {31'h0, s[STS_BUSY_BIT]});
  endtask
  // Sends one byte, with optional start and stop, and compares its acknowledge.
  task automatic send(input logic [7:0] b, input logic st, input logic sp, input logic nack);
    logic [31:0] c;
    logic [31:0] s;
    c = 32'h0;
    c[CMD_DATA_LSB +: 8] = b;
    c[CMD_START_BIT] = st;
    c[CMD_BYTE_BIT] = 1'b1;
    c[CMD_STOP_BIT] = sp;
    cmd(c, s);
    chk("no acknowledge", {31'h0, nack}, {31'h0, s[STS_NACK_BIT]});
  endtask
  // Waits, bounded, until the device is back in standby.
  task automatic wait_standby();
    int n = 0;
    while (standby !== 1'b1 && n < 40000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("standby", 32'h1, {31'h0, standby});
  endtask
  // Byte write with a masked top address bit, then a poll while programming.
  task automatic t_byte_poll();
    send(8'hA4, 1'b1, 1'b0, 1'b0);
    send(8'h81, 1'b0, 1'b0, 1'b0);
    send(8'h3E, 1'b0, 1'b0, 1'b0);
    send(8'h5A, 1'b0, 1'b1, 1'b0);
    send(8'hA4, 1'b1, 1'b1, 1'b1);
    chk("programming", 32'h1, {31'h0, programming});
  endtask
  // Page write across the page end, once the earlier program cycle is over.
  task automatic t_page_wrap();
    wait_standby();
    send(8'hA4, 1'b1, 1'b0, 1'b0);
    send(8'h05, 1'b0, 1'b0, 1'b0);
    send(8'h3F, 1'b0, 1'b0, 1'b0);
    send(8'h11, 1'b0, 1'b0, 1'b0);
    send(8'h22, 1'b0, 1'b1, 1'b0);
    wait_standby();
    chk_mem(32'h013E, 8'h5A);
    chk_mem(32'h053F, 8'h11);
    chk_mem(32'h0500, 8'h22);
    chk("page end", 32'h0, 32'(mem.exists(32'h0540)));
    chk("array writes", 32'h3, writes);
  endtask
  // A write under protect is taken on the link but never programmed.
  task automatic t_protect();
    @(posedge ref_clk);
    wp <= 1'b1;
    send(8'hA4, 1'b1, 1'b0, 1'b0);
    send(8'h00, 1'b0, 1'b0, 1'b0);
    send(8'h10, 1'b0, 1'b0, 1'b0);
    send(8'h77, 1'b0, 1'b1, 1'b0);
    chk("programming", 32'h0, {31'h0, programming});
    chk("array writes", 32'h3, writes);
    @(posedge ref_clk);
    wp <= 1'b0;
  endtask
  // Other strap setting: old address refused, read direction accepted.
  task automatic t_straps();
    logic [31:0] s;
    @(posedge ref_clk);
    strap_hi <= 1'b0;
    strap_lo <= 1'b1;
    send(8'hA4, 1'b1, 1'b1, 1'b1);
    wait_standby();
    send(8'hA3, 1'b1, 1'b0, 1'b0);
    cmd(32'h1 << CMD_STOP_BIT, s);
    wait_standby();
  endtask
  // Bus recovery on an idle line succeeds.
  task automatic t_recover();
    logic [31:0] s;
    cmd(32'h1 << CMD_REC_BIT, s);
    chk("recover failed", 32'h0, {31'h0, s[STS_REC_FAIL_BIT]});
    wait_standby();
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wait_standby();
    t_byte_poll();
    t_page_wrap();
    t_protect();
    t_straps();
    t_recover();
    close_out();
  end
  // Watchdog against a hang.
  initial begin
    repeat (90000) @(posedge ref_clk);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
